/* File: core/aomc_apb_slave.sv */
`timescale 1ns/1ps
`include "aomc_cfg.svh"
// APB slave with one wait state; registers sit at four times their index
module aomc_apb_slave (
  input  wire logic             clk_sys,   // System clock
  input  wire logic             rst,       // Synchronous reset
  input  aomc_pkg::aomc_apb_req_type apb_req, // Request from master
  output aomc_pkg::aomc_apb_rsp_type apb_rsp, // Answer to master
  input  wire logic [7:0]       stat_byte,  // Status register value
  input  wire logic [7:0]       feat_byte,  // Feature register value
  input  wire logic [7:0]       count_byte, // Trigger count value
  output logic                  wr_en,      // Write pulse
  output logic [7:0]            wr_idx,     // Register index written
  output logic [7:0]            wr_data     // Low byte written
);
  typedef struct packed {
    aomc_pkg::aomc_apb_rsp_type rsp; // Answer flops
  } aomc_slv_type;

  aomc_slv_type s_r;    // Registered state
  aomc_slv_type s_nxt;  // Next state
  logic [7:0]   idx;    // Decoded index
  logic         hit;    // Address maps to a register
  logic [7:0]   rd_val; // Read value

  // Address decode and read mux
  always_comb
  begin
    idx    = {2'b00, apb_req.paddr[7:2]};
    hit    = 1'b1;
    rd_val = 8'h00;
    if (apb_req.paddr[1:0] != 2'b00)
      hit = 1'b0;
    else if (idx == `AOMC_IDX_STATUS)
      rd_val = stat_byte;
    else if (idx == `AOMC_IDX_FEATURE)
      rd_val = feat_byte;
    else if (idx == `AOMC_IDX_TRIGGER_SAMPLE_COUNT)
      rd_val = count_byte;
    else if (idx != `AOMC_IDX_MODE)
      hit = 1'b0;  // Mode register is write-only and reads zero
  end

  // Ready rises in the second access cycle; answer drops after it
  always_comb
  begin
    s_nxt = '0;
    if (apb_req.psel && apb_req.penable && !s_r.rsp.pready)
    begin
      s_nxt.rsp.pready  = 1'b1;
      s_nxt.rsp.pslverr = !hit;
      s_nxt.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign apb_rsp = s_r.rsp;
  // Write takes effect at the edge where ready is sampled high
  assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite
                   && s_r.rsp.pready && hit;
  assign wr_idx  = idx;
  assign wr_data = apb_req.pwdata[7:0];
endmodule

/* File: core/aomc_cfg.svh */
`ifndef AOMC_CFG_SVH
`define AOMC_CFG_SVH
// Register indices; byte address is four times the index
`define AOMC_IDX_STATUS      8'h08
`define AOMC_IDX_FEATURE     8'h0D
`define AOMC_IDX_MODE        8'h10
`define AOMC_IDX_TRIGGER_SAMPLE_COUNT  8'h29
// Mode control field positions
`define AOMC_MODE_LSB        0
`define AOMC_MODE_MSB        2
`define AOMC_RESV_BIT        3
`define AOMC_XPD_BIT         4
`define AOMC_ZPD_BIT         6
`define AOMC_COUNTED_TRIGGER_MODE_BIT        7
// Feature field positions
`define AOMC_EXT_POL_BIT     6
`define AOMC_EXT_EN_BIT      7
// Reset values
`define AOMC_MODE_RST        8'h00
`define AOMC_FEATURE_RST     8'h00
`define AOMC_TRIGGER_SAMPLE_COUNT_RST  8'h00
// Trigger count meaning continuous sampling
`define AOMC_COUNT_CONT      8'hFF
// Timing: clock rate and least status lag
`define AOMC_CLK_KHZ         125000
`define AOMC_STATUS_LAG_MS   2
`define AOMC_HB_DIV          16
`endif

/* File: core/aomc_heartbeat.sv */
`timescale 1ns/1ps
`include "aomc_cfg.svh"
// Internal heartbeat: one tick pulse every DIV clocks
module aomc_heartbeat #(
  parameter int DIV = `AOMC_HB_DIV  // Clocks per heartbeat
) (
  input  wire logic clk_sys,  // System clock
  input  wire logic rst,      // Synchronous reset
  output logic      tick      // One-cycle heartbeat pulse
);
  typedef struct packed {
    logic [15:0] cnt;  // Divider count
    logic        tick; // Tick flop
  } aomc_hb_type;

  aomc_hb_type hb_r;    // Registered state
  aomc_hb_type hb_nxt;  // Next state

  // Count down, pulse at wrap
  always_comb
  begin
    hb_nxt = hb_r;
    hb_nxt.tick = 1'b0;
    if (hb_r.cnt == 16'h0000)
    begin
      hb_nxt.cnt  = 16'(DIV - 1);
      hb_nxt.tick = 1'b1;
    end
    else
    begin
      hb_nxt.cnt = hb_r.cnt - 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      hb_r <= '0;
    else
      hb_r <= hb_nxt;
  end

  assign tick = hb_r.tick;
endmodule

/* File: core/aomc_pkg.sv */
package aomc_pkg;
  // Operating modes, one-hot
  typedef enum logic [5:0] {
    M_LOWEST  = 6'b00_0001,  // Lowest-power idle
    M_IDLE    = 6'b00_0010,  // Clocked idle
    M_WATCH   = 6'b00_0100,  // Activity watch
    M_WAKE    = 6'b00_1000,  // Continuous wake
    M_COMBINE = 6'b01_0000,  // Watch plus wake
    M_COUNTED = 6'b10_0000   // Counted trigger
  } aomc_mode_type;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } aomc_apb_req_type;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } aomc_apb_rsp_type;

  // Controller state
  typedef struct packed {
    aomc_mode_type mode;       // Current mode
    logic [7:0]    ctrl;       // Internal copy of mode control
    logic          pend;       // Software write waits for heartbeat
    logic [7:0]    pend_val;   // Value of that write
    logic [7:0]    trigger_sample_count; // Trigger sample count
    logic [7:0]    feature;    // External trigger settings
    logic          oneshot;    // Counted run returns to clocked idle
    logic [7:0]    taken;      // Samples requested in counted run
    logic          pin_q;      // Last pin level for edge detect
    logic [2:0]    rep_mode;   // Reported mode code
    logic [31:0]   lag_cnt;    // Status lag counter
    logic          clocks_run; // Internal clocks enabled
    logic          sniff_en;   // Activity watch enabled
    logic          sample_en;  // Sampling pipeline enabled
    logic          fifo_allow; // FIFO may operate
    logic [2:0]    axis_en;    // Axis enables, x in bit 0
    logic          sample_req; // One sample request pulse
  } aomc_state_type;
endpackage

/* File: core/aomc_top.sv */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "aomc_cfg.svh"
// Notes on behaviour
// - Mode control at 0x10, write-only, resets 0x00
// - Code 000: lowest power, clocks stopped
// - Code 001: clocks run, no sampling
// - Code 010: watch only, activity wakes device
// - Code 101: continuous sampling, watch off
// - Code 110: watch, sampling and FIFO together
// - Code 111: counted samples, then lowest idle
// - Bits 4..6 power down X, Y, Z
// - Bit 7 starts one-shot; 255 means continuous
// - One-shot count comes from register 0x29
// - One-shot only accepted from clocked idle
// - One-shot end returns to clocked idle
// - Mode change at the next heartbeat tick
// - Hardware updates mode bits on auto events
// - Reported mode lags writes by 2 ms
// - External trigger needs trigger code, no one-shot
// - Polarity bit picks falling or rising edge
module aomc_top #(
  parameter int HB_DIV         = `AOMC_HB_DIV,  // Clocks per heartbeat
  parameter int STATUS_LAG_CYC = `AOMC_STATUS_LAG_MS * `AOMC_CLK_KHZ // Status lag
) (
  input  wire logic             clk_sys,      // System clock, 125 MHz
  input  wire logic             rst,          // Synchronous reset, high
  input  aomc_pkg::aomc_apb_req_type apb_req, // APB request
  output aomc_pkg::aomc_apb_rsp_type apb_rsp, // APB answer
  input  wire logic             activity_hit,  // Activity detected pulse
  input  wire logic             active_low_interrupt_pin, // Pin level in
  output logic                  clocks_run,    // Internal clocks enabled
  output logic                  sniff_en,      // Activity watch enabled
  output logic                  sample_en,     // Sampling pipeline enabled
  output logic                  fifo_allow,    // FIFO may operate
  output logic [2:0]            axis_en,       // Axis enables, x in bit 0
  output logic                  sample_req,    // One sample request pulse
  output logic [2:0]            mode_code      // Reported mode code
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int HB_WAIT = HB_DIV + 2;  // Bound on mode change wait

  aomc_pkg::aomc_state_type st_r;    // Registered state
  aomc_pkg::aomc_state_type st_nxt;  // Next state
  logic       hb_tick;               // Heartbeat pulse
  logic       wr_en;                 // Register write pulse
  logic [7:0] wr_idx;                // Index written
  logic [7:0] wr_data;               // Data written
  logic       pin_edge;              // Selected pin edge seen
  logic       pace;                  // Counted sample pacing event
  logic [7:0] count_eff;             // Count with zero read as one
  logic       run_done;              // Counted run ends this cycle

  // Code to mode, for legal codes
  function automatic aomc_pkg::aomc_mode_type mode_of(input logic [2:0] c);
    aomc_pkg::aomc_mode_type m;
    m = aomc_pkg::M_LOWEST;
    unique case (c)
      3'b001:  m = aomc_pkg::M_IDLE;
      3'b010:  m = aomc_pkg::M_WATCH;
      3'b101:  m = aomc_pkg::M_WAKE;
      3'b110:  m = aomc_pkg::M_COMBINE;
      3'b111:  m = aomc_pkg::M_COUNTED;
      default: m = aomc_pkg::M_LOWEST;
    endcase
    return m;
  endfunction

  // Mode to code
  function automatic logic [2:0] code_of(input aomc_pkg::aomc_mode_type m);
    logic [2:0] c;
    c = 3'b000;
    unique case (m)
      aomc_pkg::M_LOWEST:  c = 3'b000;
      aomc_pkg::M_IDLE:    c = 3'b001;
      aomc_pkg::M_WATCH:   c = 3'b010;
      aomc_pkg::M_WAKE:    c = 3'b101;
      aomc_pkg::M_COMBINE: c = 3'b110;
      aomc_pkg::M_COUNTED: c = 3'b111;
    endcase
    return c;
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  // Heartbeat pacing of mode changes
  aomc_heartbeat #(
    .DIV (HB_DIV)
  ) u_hb (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (hb_tick)
  );

  // Register access over APB
  aomc_apb_slave u_apb (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .apb_req    (apb_req),
    .apb_rsp    (apb_rsp),
    .stat_byte  ({5'b0_0000, st_r.rep_mode}),
    .feat_byte  (st_r.feature),
    .count_byte (st_r.trigger_sample_count),
    .wr_en      (wr_en),
    .wr_idx     (wr_idx),
    .wr_data    (wr_data)
  );

  // ****************************************************************
  // Sample pacing
  // ****************************************************************
  // Edge on the pin as chosen by polarity, 0 falling, 1 rising
  always_comb
  begin
    if (st_r.feature[`AOMC_EXT_POL_BIT])
      pin_edge = active_low_interrupt_pin && !st_r.pin_q;
    else
      pin_edge = !active_low_interrupt_pin && st_r.pin_q;
    // External edges pace counted mode when enabled, else heartbeat
    pace = st_r.feature[`AOMC_EXT_EN_BIT] ? pin_edge : hb_tick;
    count_eff = (st_r.trigger_sample_count == 8'h00) ? 8'h01 : st_r.trigger_sample_count;
    // Count of 255 never ends the run
    run_done = (st_r.mode == aomc_pkg::M_COUNTED) && pace
               && (st_r.trigger_sample_count != `AOMC_COUNT_CONT)
               && (st_r.taken + 8'h01 == count_eff);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pin_q = active_low_interrupt_pin;
    st_nxt.sample_req = 1'b0;

    // Configuration writes
    if (wr_en && wr_idx == `AOMC_IDX_MODE)
    begin
      st_nxt.pend     = 1'b1;  // Wait for heartbeat
      st_nxt.pend_val = wr_data;
    end
    if (wr_en && wr_idx == `AOMC_IDX_TRIGGER_SAMPLE_COUNT)
      st_nxt.trigger_sample_count = wr_data;
    if (wr_en && wr_idx == `AOMC_IDX_FEATURE)
      st_nxt.feature = wr_data & 8'hC0;

    // Counted run: request a sample on each pacing event
    if (st_r.mode == aomc_pkg::M_COUNTED && pace)
    begin
      st_nxt.sample_req = 1'b1;
      st_nxt.taken      = st_r.taken + 8'h01;
      if (run_done)
      begin
        // One-shot ends in clocked idle, mode code run in lowest idle
        st_nxt.mode = st_r.oneshot ? aomc_pkg::M_IDLE : aomc_pkg::M_LOWEST;
        st_nxt.ctrl[2:0] = code_of(st_nxt.mode);
        st_nxt.taken = 8'h00;
      end
    end

    // Activity while watching moves to continuous wake
    if (st_r.mode == aomc_pkg::M_WATCH && activity_hit)
    begin
      st_nxt.mode      = aomc_pkg::M_WAKE;
      st_nxt.ctrl[2:0] = 3'b101;
    end

    // Pending software write applied at the heartbeat
    if (st_r.pend && hb_tick)
    begin
      // A mode write landing on this same tick stays pending: set wins
      st_nxt.pend = wr_en && (wr_idx == `AOMC_IDX_MODE);
      st_nxt.ctrl[6:4] = st_r.pend_val[6:4];
      if (st_r.pend_val[`AOMC_COUNTED_TRIGGER_MODE_BIT])
      begin
        // One-shot only from clocked idle and not with external trigger
        if (st_r.mode == aomc_pkg::M_IDLE
            && !st_r.feature[`AOMC_EXT_EN_BIT])
        begin
          st_nxt.mode      = aomc_pkg::M_COUNTED;
          st_nxt.oneshot   = 1'b1;
          st_nxt.taken     = 8'h00;
          st_nxt.ctrl[2:0] = 3'b111;
        end
      end
      else if (st_r.pend_val[2:0] != 3'b011 && st_r.pend_val[2:0] != 3'b100)
      begin
        // Legal code; reserved codes and bit 3 are dropped
        st_nxt.mode      = mode_of(st_r.pend_val[2:0]);
        st_nxt.oneshot   = 1'b0;
        st_nxt.taken     = 8'h00;
        st_nxt.ctrl[2:0] = st_r.pend_val[2:0];
      end
    end

    // Enables per mode
    st_nxt.clocks_run = 1'b1;
    st_nxt.sniff_en   = 1'b0;
    st_nxt.sample_en  = 1'b0;
    st_nxt.fifo_allow = 1'b0;
    unique case (st_nxt.mode)
      aomc_pkg::M_LOWEST:  st_nxt.clocks_run = 1'b0;
      aomc_pkg::M_IDLE:    st_nxt.clocks_run = 1'b1;
      aomc_pkg::M_WATCH:   st_nxt.sniff_en   = 1'b1;
      aomc_pkg::M_WAKE:
      begin
        st_nxt.sample_en  = 1'b1;
        st_nxt.fifo_allow = 1'b1;
      end
      aomc_pkg::M_COMBINE:
      begin
        st_nxt.sniff_en   = 1'b1;
        st_nxt.sample_en  = 1'b1;
        st_nxt.fifo_allow = 1'b1;
      end
      aomc_pkg::M_COUNTED:
      begin
        st_nxt.sample_en  = 1'b1;
        st_nxt.fifo_allow = 1'b1;
      end
    endcase
    st_nxt.axis_en = ~st_nxt.ctrl[6:4];

    // Reported mode follows only after the lag has run out
    if (code_of(st_nxt.mode) == st_r.rep_mode)
      st_nxt.lag_cnt = 32'h0000_0000;
    else if (code_of(st_nxt.mode) != code_of(st_r.mode))
      st_nxt.lag_cnt = 32'h0000_0000;  // Restart on a new mode
    else if (st_r.lag_cnt + 32'h0000_0001 >= 32'(STATUS_LAG_CYC))
    begin
      st_nxt.rep_mode = code_of(st_r.mode);
      st_nxt.lag_cnt  = 32'h0000_0000;
    end
    else
      st_nxt.lag_cnt = st_r.lag_cnt + 32'h0000_0001;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_r            <= '0;
      st_r.mode       <= aomc_pkg::M_LOWEST;
      st_r.ctrl       <= `AOMC_MODE_RST;
      st_r.trigger_sample_count <= `AOMC_TRIGGER_SAMPLE_COUNT_RST;
      st_r.feature    <= `AOMC_FEATURE_RST;
      st_r.axis_en    <= 3'b111;
      st_r.pin_q      <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from flops
  assign clocks_run = st_r.clocks_run;
  assign sniff_en   = st_r.sniff_en;
  assign sample_en  = st_r.sample_en;
  assign fifo_allow = st_r.fifo_allow;
  assign axis_en    = st_r.axis_en;
  assign sample_req = st_r.sample_req;
  assign mode_code  = st_r.rep_mode;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_reset_lowest: assert property (@(posedge clk_sys) rst |=>
    st_r.mode == aomc_pkg::M_LOWEST && axis_en == 3'b111 && !clocks_run)
    else $error("reset did not select lowest idle");

  a_lowest_stopped: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.mode == aomc_pkg::M_LOWEST |-> !clocks_run && !sample_en && !sniff_en)
    else $error("lowest idle has activity");

  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.mode == aomc_pkg::M_IDLE |-> clocks_run && !sample_en && !sniff_en)
    else $error("clocked idle wrong enables");

  a_watch_wakes: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.mode == aomc_pkg::M_WATCH && activity_hit && !(st_r.pend && hb_tick)
    |=> st_r.mode == aomc_pkg::M_WAKE && sample_en && !sniff_en)
    else $error("activity did not wake");

  a_wake_enables: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.mode == aomc_pkg::M_WAKE |-> sample_en && !sniff_en && clocks_run)
    else $error("continuous wake enables wrong");

  a_combined_all: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.mode == aomc_pkg::M_COMBINE |-> sniff_en && sample_en && fifo_allow)
    else $error("combined mode enables wrong");

  a_counted_run: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.mode == aomc_pkg::M_COUNTED |-> sample_en && fifo_allow && !sniff_en)
    else $error("counted mode enables wrong");

  a_axis_follow: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.pend && hb_tick |=> axis_en == ~$past(st_r.pend_val[6:4]))
    else $error("axis enables not applied");

  a_endless_run: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.mode == aomc_pkg::M_COUNTED && st_r.trigger_sample_count == `AOMC_COUNT_CONT
    && !(st_r.pend && hb_tick) |=> st_r.mode == aomc_pkg::M_COUNTED)
    else $error("endless run stopped");

  a_oneshot_end: assert property (@(posedge clk_sys) disable iff (rst)
    run_done && st_r.oneshot && !(st_r.pend && hb_tick)
    |=> st_r.mode == aomc_pkg::M_IDLE && st_r.ctrl[2:0] == 3'b001)
    else $error("one-shot did not return to clocked idle");

  a_counted_trigger_mode_refused: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.pend && hb_tick && st_r.pend_val[7] && st_r.mode != aomc_pkg::M_IDLE
    && !run_done && !activity_hit |=> st_r.mode == $past(st_r.mode))
    else $error("one-shot taken outside clocked idle");

  a_mode_latency: assert property (@(posedge clk_sys) disable iff (rst)
    wr_en && wr_idx == `AOMC_IDX_MODE && wr_data[2:0] == 3'b101 && !wr_data[7]
    |-> ##[1:HB_WAIT] st_r.mode == aomc_pkg::M_WAKE)
    else $error("mode change too slow");

  a_reserved_keep: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.pend && hb_tick && !st_r.pend_val[7] && st_r.pend_val[2:0] == 3'b011
    && !run_done && !activity_hit |=> st_r.mode == $past(st_r.mode))
    else $error("reserved code changed mode");

  a_status_lag: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(st_r.rep_mode) |-> $past(st_r.lag_cnt) + 32'h0000_0001
    >= 32'(STATUS_LAG_CYC))
    else $error("status mode updated early");

  c_oneshot: cover property (@(posedge clk_sys) disable iff (rst)
    run_done && st_r.oneshot);

  c_wake: cover property (@(posedge clk_sys) disable iff (rst)
    st_r.mode == aomc_pkg::M_WATCH && activity_hit);

  c_ext_edge: cover property (@(posedge clk_sys) disable iff (rst)
    st_r.mode == aomc_pkg::M_COUNTED && st_r.feature[7] && pin_edge);

  c_status: cover property (@(posedge clk_sys) disable iff (rst)
    $changed(st_r.rep_mode));
endmodule

/* File: tb/aomc_tb.sv */
`timescale 1ns/1ps
`include "aomc_cfg.svh"
module tb;
  // ****************************************
  // Parameters and signals
  // ****************************************
  localparam int HB  = 4;  // Short heartbeat for simulation
  localparam int LAG = 8;  // Short status lag for simulation
  localparam logic [7:0] A_STAT = 8'(`AOMC_IDX_STATUS * 4);     // Status address
  localparam logic [7:0] A_FEAT = 8'(`AOMC_IDX_FEATURE * 4);    // Feature address
  localparam logic [7:0] A_MODE = 8'(`AOMC_IDX_MODE * 4);       // Mode control address
  localparam logic [7:0] A_CNT  = 8'(`AOMC_IDX_TRIGGER_SAMPLE_COUNT * 4); // Trigger count address
  logic                       clk_sys;      // System clock
  logic                       rst;          // Synchronous reset
  logic                       activity_hit; // Activity pulse
  logic                       pin;          // Trigger pin level
  aomc_pkg::aomc_apb_req_type apb_req;      // Bus request
  aomc_pkg::aomc_apb_rsp_type apb_rsp;      // Bus answer
  logic                       clocks_run;   // Clock enable seen
  logic                       sniff_en;     // Watch enable seen
  logic                       sample_en;    // Sampling enable seen
  logic                       fifo_allow;   // FIFO enable seen
  logic                       sample_req;   // Sample pulse seen
  logic [2:0]                 axis_en;      // Axis enables seen
  logic [2:0]                 mode_code;    // Reported code
  logic [33:0]                exp_q[$];     // Expected answers: rd flag, err, data
  logic [33:0]                e;            // Note taken off the queue
  logic [2:0]                 codes[5];     // Regular mode codes
  logic [3:0]                 r;            // Random bits
  logic                       pol;          // Edge polarity under test
  int                         fail_count;   // Mismatches
  int                         num_checks;   // Comparisons
  int                         samples;      // Sample pulses counted
  int                         seed;         // Random seed
  int                         i;            // Loop index

  aomc_top #(.HB_DIV(HB), .STATUS_LAG_CYC(LAG)) uut (
    .clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .activity_hit(activity_hit), .active_low_interrupt_pin(pin),
    .clocks_run(clocks_run), .sniff_en(sniff_en), .sample_en(sample_en),
    .fifo_allow(fifo_allow), .axis_en(axis_en), .sample_req(sample_req),
    .mode_code(mode_code));

  // Clock of 8 ns period
  always #4 clk_sys = ~clk_sys;

  // ****************************************
  // Helpers
  // ****************************************
  // Compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Enables expected per mode code: clocks, watch, sampling, FIFO
  function automatic logic [3:0] exp_en(input logic [2:0] c);
    case (c)
      3'b000:  return 4'b0000;
      3'b001:  return 4'b1000;
      3'b010:  return 4'b1100;
      3'b110:  return 4'b1111;
      default: return 4'b1011;
    endcase
  endfunction

  // Enable outputs gathered in one word
  function automatic logic [31:0] got_en();
    return {25'h0, clocks_run, sniff_en, sample_en, fifo_allow, axis_en};
  endfunction

  // One bus transfer; the expected answer is queued for the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] ed, input logic ee);
    exp_q.push_back({~wr, ee, 24'h0, ed});
    @(posedge clk_sys);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= {24'($random(seed)), d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // Hold the request until ready is sampled high at a rising edge
    do
      @(posedge clk_sys);
    while (apb_rsp.pready !== 1'b1);
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic err = 1'b0);
    apb(1'b1, a, d, 8'h00, err);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic err = 1'b0);
    apb(1'b0, a, 8'h00, d, err);
  endtask

  // Wait out a mode change, check enables, then the reported code
  task automatic expect_mode(input logic [2:0] c, input logic [2:0] ax);
    repeat (3 * HB + 2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("enables", {25'h0, exp_en(c), ax}, got_en());
    repeat (LAG + 2) @(posedge clk_sys);
    rd(A_STAT, {5'h0, c});
    check("mode code", {29'h0, c}, {29'h0, mode_code});
  endtask

  // Verdict and end of run
  task automatic results;
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Monitor: bus answers and sample pulses
  // ****************************************
  // Bus answer taken at the rising edge where ready is sampled high
  always @(posedge clk_sys)
  begin
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check("pslverr", {31'h0, e[32]}, {31'h0, apb_rsp.pslverr});
      if (e[33])
        check("prdata", {24'h0, e[7:0]}, apb_rsp.prdata);
    end
  end

  // Sample pulses counted where they are settled
  always @(negedge clk_sys)
  begin
    if (sample_req === 1'b1)
      samples++;
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 32'hb788;
    clk_sys = 1'b0;
    rst = 1'b1;
    activity_hit = 1'b0;
    pin = 1'b1;
    apb_req = '0;
    fail_count = 0;
    num_checks = 0;
    samples = 0;
    codes = '{3'b001, 3'b010, 3'b101, 3'b110, 3'b000};
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("reset enables", 32'h7, got_en());
    rd(A_STAT, 8'h00);
    rd(A_MODE, 8'h00);
    rd(A_CNT, 8'h00);
    rd(8'h44, 8'h00, 1'b1);
    rd(8'h41, 8'h00, 1'b1);
    // Every regular code, random axis and reserved bit
    for (i = 0; i < 5; i++)
    begin
      r = 4'($random(seed));
      wr(A_MODE, {1'b0, r[2:0], r[3], codes[i]});
      expect_mode(codes[i], ~r[2:0]);
    end
    // Reserved codes keep the mode, axis bits still land
    wr(A_MODE, 8'h01);
    expect_mode(3'b001, 3'b111);
    wr(A_MODE, 8'h13);
    expect_mode(3'b001, 3'b110);
    wr(A_MODE, 8'h24);
    expect_mode(3'b001, 3'b101);
    // Activity in watch wakes the device
    wr(A_MODE, 8'h02);
    expect_mode(3'b010, 3'b111);
    activity_hit <= 1'b1;
    @(posedge clk_sys);
    activity_hit <= 1'b0;
    expect_mode(3'b101, 3'b111);
    // Counted code: three samples, then lowest power
    wr(A_CNT, 8'h03);
    rd(A_CNT, 8'h03);
    samples = 0;
    wr(A_MODE, 8'h07);
    repeat (6 * HB + 4) @(posedge clk_sys);
    expect_mode(3'b000, 3'b111);
    check("samples", 32'd3, samples);
    // One-shot refused outside clocked idle
    samples = 0;
    wr(A_MODE, 8'h80);
    expect_mode(3'b000, 3'b111);
    check("samples", 32'd0, samples);
    // One-shot of two samples returns to clocked idle
    wr(A_MODE, 8'h01);
    expect_mode(3'b001, 3'b111);
    wr(A_CNT, 8'h02);
    samples = 0;
    wr(A_MODE, 8'h80);
    repeat (6 * HB) @(posedge clk_sys);
    expect_mode(3'b001, 3'b111);
    check("samples", 32'd2, samples);
    // Count 255 never ends until software steps in
    wr(A_CNT, 8'hFF);
    samples = 0;
    wr(A_MODE, 8'h80);
    repeat (20 * HB) @(posedge clk_sys);
    check("endless run", {25'h0, exp_en(3'b111), 3'b111}, got_en());
    check("endless samples", 32'h1, {31'h0, samples > 15});
    wr(A_MODE, 8'h01);
    expect_mode(3'b001, 3'b111);
    // External edge trigger, both polarities
    for (i = 0; i < 2; i++)
    begin
      pol = i[0];
      pin <= ~pol;
      wr(A_FEAT, {1'b1, pol, 6'h00});
      rd(A_FEAT, {1'b1, pol, 6'h00});
      wr(A_CNT, 8'h02);
      wr(A_MODE, 8'h07);
      repeat (3 * HB + 2) @(posedge clk_sys);
      samples = 0;
      pin <= pol;
      repeat (3 * HB + 2) @(posedge clk_sys);
      check("edge samples", 32'd1, samples);
      check("edge run", {25'h0, exp_en(3'b111), 3'b111}, got_en());
      wr(A_MODE, 8'h01);
      expect_mode(3'b001, 3'b111);
      wr(A_MODE, 8'h80);
      expect_mode(3'b001, 3'b111);
    end
    results();
  end
endmodule
